/* File: core/crb_pkg.sv */
// Constants, register map and codes shared by the card reporter block.
// Assumes a 250 MHz system clock and a classic Wishbone register bus.
package crb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = (T_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S = 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADR_NODE = 8'h00;
  localparam logic [7:0] ADR_SADDR = 8'h04;
  localparam logic [7:0] ADR_INTERVAL = 8'h08;
  localparam logic [7:0] ADR_HOLD = 8'h0C;
  localparam logic [7:0] ADR_MODE = 8'h10;
  localparam logic [7:0] ADR_KEY_LO = 8'h14;
  localparam logic [7:0] ADR_KEY_HI = 8'h18;
  localparam logic [7:0] ADR_PWD = 8'h1C;
  localparam logic [7:0] ADR_UNLOCK = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam logic [7:0] ADR_NUM_LO = 8'h28;
  localparam logic [7:0] ADR_NUM_HI = 8'h2C;
  localparam logic [7:0] ADR_VERSION = 8'h30;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] NODE_RST = 8'h04;
  localparam logic [7:0] SADDR_RST = 8'h09;
  localparam logic [15:0] INTERVAL_RST = 16'h03E9;
  localparam logic [7:0] HOLD_RST = 8'h01;
  localparam logic [7:0] MODE_SECURE = 8'h00;
  localparam logic [7:0] MODE_INSECURE = 8'h02;
  localparam logic [47:0] KEY_RST = 48'hFFFF_FFFF_FFFF;
  localparam logic [31:0] PWD_RST = 32'h0000_2B67;
  // Arbitrary identification text, not tied to any product
  localparam logic [31:0] VERSION_TEXT_DEF = 32'h5645_5231;

  ////////////////////////////////////////////////////////////////////////////
  // Card and frame layout
  localparam logic [7:0] CARD_SECTOR = 8'h04;
  localparam logic [19:0] IDENT_MIN = 20'h0_0001;
  localparam logic [19:0] IDENT_MAX = 20'hF_423F;
  localparam logic [23:0] PGN_CARD = 24'h18_F701;
  localparam int unsigned STATUS_LSB = 0;
  localparam int unsigned NUMBER_LSB = 16;
  localparam int unsigned NUMBER_W = 40;
  localparam int unsigned FRAME_W = 93;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0] CMD_NUMBER = 8'h01;
  localparam logic [7:0] CMD_VERSION = 8'h02;

  typedef enum logic [7:0] {
    ST_NONE = 8'h01,
    ST_FOREIGN = 8'h03,
    ST_OWN = 8'h07
  } crb_status_t;

  typedef enum logic [1:0] {
    SND_IDLE = 2'b01,
    SND_PUSH = 2'b10
  } crb_send_t;

  function automatic logic crb_ident_ok(input logic [19:0] ident);
    crb_ident_ok = (ident >= IDENT_MIN) && (ident <= IDENT_MAX);
  endfunction : crb_ident_ok

endpackage : crb_pkg

/* File: core/crb_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; ce low freezes every register.
`timescale 1ns/1ps
`default_nettype none
module crb_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D+1)-1:0] count
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(D+1)-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != D[$clog2(D+1)-1:0]);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign count = count_reg;
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{($clog2(D+1)-1){1'b0}}, push} - {{($clog2(D+1)-1){1'b0}}, pop};
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (!arst_n)
    count_reg <= D[$clog2(D+1)-1:0])
    else $error("fifo count above depth");
endmodule : crb_fifo
`default_nettype wire

/* File: core/crb_card_eval.sv */
// Turns one raw card read into a status code and card number.
// Assumes the radio front end and the stored-card lookup answer in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module crb_card_eval (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Mode and raw read
  input wire logic secure,
  input wire logic rd_valid,
  input wire logic [39:0] rd_uid,
  input wire logic [7:0] rd_sector,
  input wire logic [19:0] rd_ident,
  input wire logic rd_known,
  // Evaluated read
  output logic ev_valid,
  output logic [7:0] ev_status,
  output logic [39:0] ev_number
);
  import crb_pkg::*;
  logic accept;

  // In secure mode, reads from other sectors or out-of-range identifiers are dropped; insecure mode accepts every read
  assign accept = secure ? (rd_sector == CARD_SECTOR) && crb_ident_ok(rd_ident) // see R3 see R2
                         : 1'b1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ev_valid <= 1'b0;
      ev_status <= ST_NONE;
      ev_number <= '0;
    end
    else if (ce)
    begin
      ev_valid <= rd_valid && accept;
      if (rd_valid && accept)
      begin
        if (secure)
        begin
          ev_status <= rd_known ? ST_OWN : ST_FOREIGN; // see R15 see R6
          ev_number <= {20'h0_0000, rd_ident};
        end
        else
        begin
          // Chip UID only, never looked up in the stored list
          ev_status <= ST_FOREIGN; // see R17
          ev_number <= rd_uid;
        end
      end
    end
  end

  chk_ident_range: assert property (@(posedge clk) disable iff (!arst_n) // see R2
    ce && rd_valid && secure && !crb_ident_ok(rd_ident) |=> !ev_valid)
    else $error("out of range identifier accepted");
  chk_sector_four: assert property (@(posedge clk) disable iff (!arst_n) // see R3
    ce && rd_valid && secure && (rd_sector != CARD_SECTOR) |=> !ev_valid)
    else $error("read from wrong sector accepted");
endmodule : crb_card_eval
`default_nettype wire

/* File: core/crb_reporter.sv */
// Card reporter: configuration registers, periodic card frames, serial replies.
// Assumes a Wishbone classic master, a CAN transmitter with valid/ready,
// and a serial front end that delivers decoded requests.
//
// Notes on behaviour
// R1 - A version query returns a fixed identifying version text.
// R2 - Card identifier must be within 1 to 999999 inclusive.
// R3 - Card identity is read only from sector 4.
// R4 - Operator may lock unused card sectors; recommended, not required.
// R5 - Card number is broadcast on CAN; serial link returns it only on request.
// R6 - Status 01 no card, 03 foreign card, 07 own card.
// R7 - Frame group 18F701: status at bit 0 width 8, number bit 16 width 40.
// R8 - Node address is one configurable byte, default 4.
// R9 - Serial link address is one configurable byte, default 9.
// R10 - Send interval is two bytes in milliseconds, default 1001.
// R11 - Valid data hold time is one byte in seconds, default 1.
// R12 - Mode 0 secure (default), mode 2 insecure without read key.
// R13 - Six-byte card read key is used in secure mode.
// R14 - Terminal access guarded by a password, default 11111.
// R15 - Secure mode reports own if stored, else foreign, always with number.
// R16 - Serial link sends only the card number, no validity.
// R17 - Insecure mode uses the chip UID only, no data memory.
// R18 - Status returns to not-detected after hold time without a new read.
// R19 - Frame sent once each send interval with the node address.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module crb_reporter #(
  parameter int unsigned CYC_PER_MS = crb_pkg::CYC_PER_MS,
  parameter int unsigned FIFO_DEPTH = crb_pkg::FIFO_DEPTH,
  parameter logic [31:0] VERSION_TEXT = crb_pkg::VERSION_TEXT_DEF
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Raw card read
  input wire logic rd_valid,
  input wire logic [39:0] rd_uid,
  input wire logic [7:0] rd_sector,
  input wire logic [19:0] rd_ident,
  input wire logic rd_known,
  // Radio key
  output logic [47:0] rf_key,
  output logic rf_key_en,
  // CAN frame out
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [28:0] tx_id,
  output logic [63:0] tx_data,
  // Serial requests
  input wire logic ser_req_valid,
  input wire logic [7:0] ser_req_addr,
  input wire logic [7:0] ser_req_cmd,
  output logic ser_rsp_valid,
  output logic [39:0] ser_rsp_data,
  // Card state
  output logic [7:0] card_status
);
  import crb_pkg::*;

  localparam int unsigned MSW = $clog2(CYC_PER_MS);
  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  logic [7:0] node_reg;
  logic [7:0] saddr_reg;
  logic [15:0] interval_reg;
  logic [7:0] hold_reg;
  logic [7:0] mode_reg;
  logic [47:0] key_reg;
  logic [31:0] pwd_reg;
  logic unlocked_reg;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic bus_req;
  logic bus_wr;
  logic secure;
  logic ev_valid;
  logic [7:0] ev_status;
  logic [39:0] ev_number;
  logic [7:0] status_reg;
  logic [39:0] number_reg;
  logic [MSW-1:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [9:0] sec_ms_reg;
  logic [7:0] hold_left_reg;
  logic sec_tick;
  logic hold_expire;
  logic [15:0] send_ms_reg;
  logic send_due;
  crb_send_t snd_reg;
  crb_send_t snd_next;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FRAME_W-1:0] frame_word;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FRAME_W-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = ce && bus_req && wb_we_i;
  assign secure = (mode_reg == MODE_SECURE);

  always_comb
  begin
    case (wb_adr_i)
      ADR_NODE: rd_val = {24'h00_0000, node_reg};
      ADR_SADDR: rd_val = {24'h00_0000, saddr_reg};
      ADR_INTERVAL: rd_val = {16'h0000, interval_reg};
      ADR_HOLD: rd_val = {24'h00_0000, hold_reg};
      ADR_MODE: rd_val = {24'h00_0000, mode_reg};
      ADR_KEY_LO: rd_val = key_reg[31:0];
      ADR_KEY_HI: rd_val = {16'h0000, key_reg[47:32]};
      ADR_UNLOCK: rd_val = {31'h0000_0000, unlocked_reg};
      ADR_STATUS: rd_val = {16'h0000, {(8-CW){1'b0}}, fifo_count, status_reg};
      ADR_NUM_LO: rd_val = number_reg[31:0];
      ADR_NUM_HI: rd_val = {24'h00_0000, number_reg[39:32]};
      ADR_VERSION: rd_val = VERSION_TEXT; // see R1
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Password slot reads as zero and unlock slot shows only its bit 0, so partial writes clear other bytes
  assign wr_val = merge_bytes(rd_val, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_val : 32'h0000_0000;
    end
  end

  // Settings change only while the terminal is unlocked
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      node_reg <= NODE_RST;
      saddr_reg <= SADDR_RST;
      interval_reg <= INTERVAL_RST;
      hold_reg <= HOLD_RST;
      mode_reg <= MODE_SECURE;
      key_reg <= KEY_RST;
      pwd_reg <= PWD_RST;
    end
    else if (bus_wr && unlocked_reg)
    begin
      case (wb_adr_i)
        ADR_NODE: node_reg <= wr_val[7:0]; // see R8
        ADR_SADDR: saddr_reg <= wr_val[7:0]; // see R9
        ADR_INTERVAL: interval_reg <= wr_val[15:0]; // see R10
        ADR_HOLD: hold_reg <= wr_val[7:0]; // see R11
        ADR_MODE:
        begin
          if (wr_val[7:0] == MODE_SECURE || wr_val[7:0] == MODE_INSECURE)
          begin
            mode_reg <= wr_val[7:0]; // see R12
          end
        end
        ADR_KEY_LO: key_reg[31:0] <= wr_val; // see R13
        ADR_KEY_HI: key_reg[47:32] <= wr_val[15:0]; // see R13
        ADR_PWD: pwd_reg <= wr_val; // see R14
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unlocked_reg <= 1'b0;
    end
    else if (bus_wr && wb_adr_i == ADR_UNLOCK)
    begin
      unlocked_reg <= (wr_val == pwd_reg); // see R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card evaluation and key

  crb_card_eval u_eval (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .secure(secure),
    .rd_valid(rd_valid),
    .rd_uid(rd_uid),
    .rd_sector(rd_sector),
    .rd_ident(rd_ident),
    .rd_known(rd_known),
    .ev_valid(ev_valid),
    .ev_status(ev_status),
    .ev_number(ev_number)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rf_key <= 48'h0000_0000_0000;
      rf_key_en <= 1'b0;
    end
    else if (ce)
    begin
      rf_key_en <= secure; // see R12
      rf_key <= secure ? key_reg : 48'h0000_0000_0000; // see R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond and second ticks

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      ms_tick_reg <= (ms_cnt_reg == MSW'(CYC_PER_MS - 1));
      ms_cnt_reg <= (ms_cnt_reg == MSW'(CYC_PER_MS - 1)) ? '0 : ms_cnt_reg + 1'b1;
    end
  end

  assign sec_tick = ms_tick_reg && (sec_ms_reg == 10'(MS_PER_S - 1));
  // A hold of 0 or 1 ends at the first second boundary after the read
  assign hold_expire = sec_tick && (status_reg != ST_NONE) && (hold_left_reg <= 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Card state and hold

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= ST_NONE;
      number_reg <= '0;
      hold_left_reg <= 8'h00;
      sec_ms_reg <= 10'h000;
    end
    else if (ce)
    begin
      if (ev_valid)
      begin
        status_reg <= ev_status; // see R6
        number_reg <= ev_number; // see R15
        hold_left_reg <= hold_reg; // see R11
        sec_ms_reg <= 10'h000;
      end
      else
      begin
        if (ms_tick_reg)
        begin
          sec_ms_reg <= sec_tick ? 10'h000 : sec_ms_reg + 1'b1;
        end
        if (hold_expire)
        begin
          status_reg <= ST_NONE; // see R18
          number_reg <= '0;
          hold_left_reg <= 8'h00;
        end
        else if (sec_tick && hold_left_reg != 8'h00)
        begin
          hold_left_reg <= hold_left_reg - 1'b1;
        end
      end
    end
  end

  assign card_status = status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Periodic frame into the FIFO

  // An interval of 0 behaves as 1 ms
  assign send_due = ms_tick_reg && ({1'b0, send_ms_reg} + 17'h0_0001 >= {1'b0, interval_reg});

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      send_ms_reg <= 16'h0000;
    end
    else if (ce && ms_tick_reg)
    begin
      send_ms_reg <= send_due ? 16'h0000 : send_ms_reg + 1'b1; // see R10
    end
  end

  // A period that falls while a frame still waits for room is skipped
  always_comb
  begin
    case (snd_reg)
      SND_IDLE: snd_next = send_due ? SND_PUSH : SND_IDLE; // see R19
      SND_PUSH: snd_next = fifo_in_ready ? SND_IDLE : SND_PUSH;
      default: snd_next = SND_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      snd_reg <= SND_IDLE;
    end
    else if (ce)
    begin
      snd_reg <= snd_next;
    end
  end

  assign fifo_in_valid = (snd_reg == SND_PUSH);
  assign frame_word[92:64] = {PGN_CARD[20:0], node_reg}; // see R19 see R5
  assign frame_word[63:56] = 8'h00;
  assign frame_word[NUMBER_LSB +: NUMBER_W] = number_reg; // see R7
  assign frame_word[15:8] = 8'h00;
  assign frame_word[STATUS_LSB +: 8] = status_reg; // see R7

  crb_fifo #(
    .W(FRAME_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(frame_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  assign fifo_out_ready = !tx_valid || tx_ready;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid <= 1'b0;
      tx_id <= '0;
      tx_data <= '0;
    end
    else if (ce && fifo_out_ready)
    begin
      tx_valid <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        tx_id <= fifo_out_data[92:64];
        tx_data <= fifo_out_data[63:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial replies

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ser_rsp_valid <= 1'b0;
      ser_rsp_data <= '0;
    end
    else if (ce)
    begin
      ser_rsp_valid <= 1'b0;
      if (ser_req_valid && ser_req_addr == saddr_reg) // see R9 see R5
      begin
        if (ser_req_cmd == CMD_NUMBER)
        begin
          ser_rsp_valid <= 1'b1;
          ser_rsp_data <= number_reg; // see R16
        end
        else if (ser_req_cmd == CMD_VERSION)
        begin
          ser_rsp_valid <= 1'b1;
          ser_rsp_data <= {8'h00, VERSION_TEXT}; // see R1
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_req_match;
    ce && ser_req_valid && ser_req_addr == saddr_reg && ser_req_cmd == CMD_NUMBER;
  endsequence

  chk_ack_single: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_status_codes: assert property ( // see R6
    status_reg == ST_NONE || status_reg == ST_FOREIGN || status_reg == ST_OWN)
    else $error("illegal card status code");
  chk_frame_layout: assert property (tx_valid |-> // see R7
    tx_data[15:8] == 8'h00 && tx_data[63:56] == 8'h00 && tx_id[28:8] == PGN_CARD[20:0])
    else $error("card frame layout wrong");
  chk_serial_number: assert property (s_req_match |=> // see R16
    ser_rsp_valid && ser_rsp_data == $past(number_reg))
    else $error("serial number reply wrong");
  chk_serial_only_req: assert property (ce && !ser_req_valid |=> !ser_rsp_valid) // see R5
    else $error("serial reply without request");
  chk_hold_clear: assert property (ce && hold_expire && !ev_valid |=> // see R18
    status_reg == ST_NONE && number_reg == 40'h00_0000_0000)
    else $error("status not cleared after hold");
  chk_mode_key: assert property (ce && !secure |=> !rf_key_en) // see R12
    else $error("read key used in insecure mode");
  chk_locked_write: assert property (bus_wr && !unlocked_reg && wb_adr_i == ADR_NODE |=> // see R14
    $stable(node_reg))
    else $error("setting changed while locked");
endmodule : crb_reporter
`default_nettype wire

/* File: sim/crb_can_sink.sv */
// CAN transmitter model on the far side of the frame port.
// Assumes the reporter offers frames with valid and waits for ready.
`timescale 1ns/1ps
`default_nettype none
module crb_can_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  // Frame side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [63:0] tx_data,
  // Capture
  output logic [31:0] frames,
  output logic [28:0] last_id,
  output logic [63:0] last_data
);
  // Ready is a register, so a stall lands one cycle late, as a real controller
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_ready <= 1'b0;
      frames <= '0;
      last_id <= '0;
      last_data <= '0;
    end
    else
    begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready)
      begin
        frames <= frames + 32'h0000_0001;
        last_id <= tx_id;
        last_data <= tx_data;
      end
    end
  end
endmodule : crb_can_sink
`default_nettype wire

/* File: sim/test_card_reader_bus_reporter.sv */
// Self-checking bench for the card reporter.
// Assumes a 1 ms tick of 10 cycles to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module test_card_reader_bus_reporter;
  import crb_pkg::*;
  logic clk = 0, arst_n = 0, we = 0, cyc = 0, rdv = 0, known = 0, sv = 0, stall = 0;
  logic [7:0] adr = '0, sec = '0, sadr = '0, scmd = '0, cst;
  logic [31:0] dat = '0, dato, q, frames;
  logic [39:0] uid = '0, srd;
  logic [19:0] ident = '0;
  logic [47:0] key;
  logic [28:0] txid, lid;
  logic [63:0] txd, ldat;
  logic ack, key_en, txv, txr, srv;
  int fails = 0, checks_done = 0;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  crb_reporter #(.CYC_PER_MS(10)) dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(dato), .wb_ack_o(ack), .rd_valid(rdv), .rd_uid(uid),
    .rd_sector(sec), .rd_ident(ident), .rd_known(known), .rf_key(key), .rf_key_en(key_en),
    .tx_valid(txv), .tx_ready(txr), .tx_id(txid), .tx_data(txd), .ser_req_valid(sv),
    .ser_req_addr(sadr), .ser_req_cmd(scmd), .ser_rsp_valid(srv), .ser_rsp_data(srd),
    .card_status(cst));
  crb_can_sink can (.clk(clk), .arst_n(arst_n), .stall(stall), .tx_valid(txv),
    .tx_ready(txr), .tx_id(txid), .tx_data(txd), .frames(frames), .last_id(lid),
    .last_data(ldat));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
    begin
      fails++;
      final_report();
    end
    q = dato;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic card(input logic [7:0] s, input logic [19:0] i, input logic k);
    rdv <= 1'b1;
    sec <= s;
    ident <= i;
    known <= k;
    @(posedge clk);
    rdv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : card
  task automatic ser(input logic [7:0] a, input logic [7:0] c, input logic e,
    input logic [39:0] x);
    sv <= 1'b1;
    sadr <= a;
    scmd <= c;
    @(posedge clk);
    sv <= 1'b0;
    #1;
    chk("ser_valid", 64'(srv), 64'(e));
    if (e)
      chk("ser_data", 64'(srd), 64'(x));
    @(posedge clk);
  endtask : ser
  // Two frames, since the first may already have been queued before the read
  task automatic frame(input logic [7:0] st, input logic [39:0] num);
    int n;
    logic [31:0] f0;
    n = 0;
    f0 = frames;
    while (frames < f0 + 2 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("frame_wait", 64'(n < 3000), 64'h1);
    if (n >= 3000)
      final_report();
    chk("frame_id", 64'(lid), 64'({PGN_CARD[20:0], 8'h21}));
    chk("frame_data", ldat, {8'h00, num, 8'h00, st});
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("key_en", 64'(key_en), 64'h1);
    chk("key", 64'(key), 64'(KEY_RST));
    wb(1'b0, ADR_NODE, '0);
    chk("node", 64'(q), 64'(NODE_RST));
    wb(1'b0, ADR_SADDR, '0);
    chk("saddr", 64'(q), 64'(SADDR_RST));
    wb(1'b0, ADR_INTERVAL, '0);
    chk("interval", 64'(q), 64'(INTERVAL_RST));
    wb(1'b0, ADR_HOLD, '0);
    chk("hold", 64'(q), 64'(HOLD_RST));
    wb(1'b0, ADR_MODE, '0);
    chk("mode", 64'(q), 64'(MODE_SECURE));
    wb(1'b0, ADR_VERSION, '0);
    chk("version", 64'(q), 64'(VERSION_TEXT_DEF));
    wb(1'b0, 8'h40, '0);
    chk("unmapped", 64'(q), 64'h0);
    wb(1'b1, ADR_NODE, 32'h0000_0021);
    wb(1'b0, ADR_NODE, '0);
    chk("locked", 64'(q), 64'(NODE_RST));
    wb(1'b1, ADR_UNLOCK, PWD_RST);
    wb(1'b0, ADR_UNLOCK, '0);
    chk("unlock", 64'(q[0]), 64'h1);
    wb(1'b1, ADR_NODE, 32'h0000_0021);
    wb(1'b1, ADR_INTERVAL, 32'h0000_0001);
    wb(1'b1, ADR_KEY_LO, 32'h1234_5678);
    chk("key_new", 64'(key), 64'h0000_FFFF_1234_5678);
    card(8'h03, 20'h0_0005, 1'b1);
    card(8'h04, 20'h0_0000, 1'b1);
    card(8'h04, 20'hF_4240, 1'b1);
    chk("refused", 64'(cst), 64'(ST_NONE));
    card(8'h04, IDENT_MAX, 1'b1);
    chk("own", 64'(cst), 64'(ST_OWN));
    wb(1'b0, ADR_NUM_LO, '0);
    chk("num_lo", 64'(q), 64'(IDENT_MAX));
    frame(ST_OWN, 40'(IDENT_MAX));
    ser(8'h09, CMD_NUMBER, 1'b1, 40'(IDENT_MAX));
    ser(8'h09, CMD_VERSION, 1'b1, 40'(VERSION_TEXT_DEF));
    ser(8'h08, CMD_NUMBER, 1'b0, '0);
    card(8'h04, IDENT_MIN, 1'b0);
    chk("foreign", 64'(cst), 64'(ST_FOREIGN));
    frame(ST_FOREIGN, 40'(IDENT_MIN));
    wb(1'b1, ADR_MODE, 32'(MODE_INSECURE));
    wb(1'b1, ADR_MODE, 32'h0000_0005);
    wb(1'b0, ADR_MODE, '0);
    chk("mode_ins", 64'(q), 64'(MODE_INSECURE));
    chk("key_off", 64'(key_en), 64'h0);
    uid <= 40'h12_3456_789A;
    card(8'h07, 20'h0_0000, 1'b1);
    frame(ST_FOREIGN, 40'h12_3456_789A);
    stall <= 1'b1;
    repeat (300) @(posedge clk);
    wb(1'b0, ADR_STATUS, '0);
    chk("fifo_full", 64'(q[15:8]), 64'(FIFO_DEPTH));
    chk("held", 64'(q[7:0]), 64'(ST_FOREIGN));
    stall <= 1'b0;
    for (int n = 0; n < 10500 && cst !== ST_NONE; n++)
      @(posedge clk);
    chk("expired", 64'(cst), 64'(ST_NONE));
    final_report();
  end
endmodule : test_card_reader_bus_reporter
`default_nettype wire
